// ### gsl_bus_master.sv
// Purpose: Master model for the two-wire bus of the gauge slave
// Assumes: Open-drain wire with pull-up, resolved in the bench
// Notes: Also plays a rival slave that answers alert responses
`timescale 1ns/100ps

module gsl_bus_master (
    // Clock
    input wire logic clk,
    // Wire level
    input wire logic sda,
    // Bus clock and pulls
    output logic scl,
    output logic sda_pull,
    output logic rival_pull
);
    // ****************************************
    // Phase timing
    // ****************************************
    // Four clk per phase, above the two the slave needs to settle
    localparam int PH = 4;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rival_pull = 1'b0;
    end

    task automatic tick();
        repeat (PH) @(posedge clk);
        #1;
    endtask

    // ****************************************
    // Conditions and bits
    // ****************************************
    // fall of data while clock high
    task automatic start_cond();
        sda_pull = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_pull = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask

    // rise of data while clock high
    task automatic stop_cond();
        sda_pull = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_pull = 1'b0;
        tick();
    endtask

    // data changes only while clock low
    task automatic bit_cycle(input logic low, output logic seen);
        sda_pull = low;
        tick();
        scl = 1'b1;
        tick();
        seen = sda;
        scl = 1'b0;
        tick();
    endtask

    // eight bits then a released ack bit
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(~b[i], s);
        end
        bit_cycle(1'b0, s);
        ack = ~s;
    endtask

    // master answers each byte it reads
    task automatic read_byte(input logic ack, input logic [7:0] rival, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            rival_pull = ~rival[i];
            bit_cycle(1'b0, s);
            d[i] = s;
        end
        rival_pull = 1'b0;
        bit_cycle(ack, s);
    endtask
endmodule // gsl_bus_master

// ### gsl_pkg.sv
// Purpose: Shared constants and types of the gauge two-wire slave
// Assumes: One clock, bus pins sampled as synchronous inputs
// Notes: Addresses are 7-bit, data and register pointer are 8-bit
package gsl_pkg;

    // ****************************************
    // Bus addresses and framing
    // ****************************************
    localparam logic [6:0] DEV_ADDR = 7'h64;
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int ALERT_MODE_BIT = 1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_CMD,
        S_WDATA,
        S_ACK,
        S_RDATA,
        S_RACK,
        S_ARA,
        S_SKIP
    } gsl_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gsl_reg_req_t;

endpackage

// ### gsl_slave.sv
// Purpose: Two-wire slave with alert response for a charge gauge
// Assumes: scl and sda are synchronous to clk; scl phases last several clk cycles
// Notes: Register file lives outside; reg_rdata must follow reg_req.addr combinationally
`timescale 1ns/100ps

module gsl_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Two-wire bus, clock is input only
    input wire logic scl,
    input wire logic sda,
    output logic sda_o,
    output logic sda_oe,
    // Alert pin, open drain
    output logic alert_charge_complete_pin_o,
    output logic alert_charge_complete_pin_oe,
    // Alert source and configuration
    input wire logic alert_event,
    input wire logic [1:0] alert_cfg,
    // Register file access
    output gsl_pkg::gsl_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Status
    output logic bus_busy
);

    // ****************************************
    // Bus edge and condition detection
    // ****************************************
    logic scl_q_ff;
    logic sda_q_ff;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl;
            sda_q_ff <= sda;
        end
    end

    assign scl_rise = scl & ~scl_q_ff;
    assign scl_fall = ~scl & scl_q_ff;
    assign bus_start = scl & scl_q_ff & sda_q_ff & ~sda;
    assign bus_stop = scl & scl_q_ff & ~sda_q_ff & sda;

    // ****************************************
    // Byte framing state
    // ****************************************
    gsl_pkg::gsl_state_t state_ff;
    gsl_pkg::gsl_state_t after_ff;
    logic [3:0] cnt_ff;
    logic [7:0] rx_ff;
    logic [7:0] tx_ff;
    logic [7:0] ptr_ff;
    logic sda_oe_ff;
    logic alert_pend_ff;
    logic alert_oe_ff;
    logic busy_ff;
    gsl_pkg::gsl_reg_req_t reg_req_ff;
    logic byte_end;
    logic own_hit;
    logic ara_hit;
    logic arb_lost;
    logic ara_done;

    assign byte_end = scl_fall & (cnt_ff == gsl_pkg::BITS_PER_BYTE);
    assign own_hit = rx_ff[7:1] == gsl_pkg::DEV_ADDR;
    // alert address only while pin asserted
    assign ara_hit = (rx_ff[7:1] == gsl_pkg::ARA_ADDR) & rx_ff[0] & alert_oe_ff;
    // lost arbitration: we let SDA float high but the line reads low
    assign arb_lost = (state_ff == gsl_pkg::S_ARA) & scl_rise & ~sda_oe_ff & ~sda;
    assign ara_done = (state_ff == gsl_pkg::S_ARA) & byte_end;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= gsl_pkg::S_IDLE;
            after_ff <= gsl_pkg::S_IDLE;
        end else if (bus_start) begin
            state_ff <= gsl_pkg::S_ADDR;
        end else if (bus_stop) begin
            state_ff <= gsl_pkg::S_IDLE;
        end else begin
            case (state_ff)
                gsl_pkg::S_ADDR: begin
                    if (byte_end) begin
                        if (own_hit) begin
                            // read direction goes straight to data
                            state_ff <= gsl_pkg::S_ACK;
                            after_ff <= rx_ff[0] ? gsl_pkg::S_RDATA : gsl_pkg::S_CMD;
                        end else if (ara_hit) begin
                            state_ff <= gsl_pkg::S_ACK;
                            after_ff <= gsl_pkg::S_ARA;
                        end else begin
                            state_ff <= gsl_pkg::S_SKIP;
                        end
                    end
                end
                gsl_pkg::S_CMD, gsl_pkg::S_WDATA: begin
                    if (byte_end) begin
                        state_ff <= gsl_pkg::S_ACK;
                        after_ff <= gsl_pkg::S_WDATA;
                    end
                end
                gsl_pkg::S_ACK: begin
                    if (scl_fall) begin
                        state_ff <= after_ff;
                    end
                end
                gsl_pkg::S_RDATA: begin
                    if (byte_end) begin
                        state_ff <= gsl_pkg::S_RACK;
                    end
                end
                gsl_pkg::S_RACK: begin
                    if (scl_fall) begin
                        state_ff <= rx_ff[0] ? gsl_pkg::S_SKIP : gsl_pkg::S_RDATA;
                    end
                end
                gsl_pkg::S_ARA: begin
                    if (arb_lost || byte_end) begin
                        state_ff <= gsl_pkg::S_SKIP;
                    end
                end
                default: begin
                    state_ff <= state_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= gsl_pkg::CNT_RST;
        end else if (bus_start || byte_end) begin
            cnt_ff <= gsl_pkg::CNT_RST;
        end else if (scl_rise && state_ff inside {gsl_pkg::S_ADDR, gsl_pkg::S_CMD,
                gsl_pkg::S_WDATA, gsl_pkg::S_RDATA, gsl_pkg::S_ARA}) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // ****************************************
    // Receive shifter and pointer
    // ****************************************
    // sample on rising clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_ff <= 8'h00;
        end else if (scl_rise && state_ff inside {gsl_pkg::S_ADDR, gsl_pkg::S_CMD,
                gsl_pkg::S_WDATA}) begin
            rx_ff <= {rx_ff[6:0], sda};
        end else if (scl_rise && state_ff == gsl_pkg::S_RACK) begin
            // Bit 0 holds the master's acknowledge level
            rx_ff <= {7'h00, sda};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_ff <= gsl_pkg::PTR_RST;
        end else if (state_ff == gsl_pkg::S_CMD && byte_end) begin
            ptr_ff <= rx_ff;
        end else if (state_ff == gsl_pkg::S_WDATA && byte_end) begin
            ptr_ff <= ptr_ff + 8'h01;
        end else if (state_ff == gsl_pkg::S_RACK && scl_rise && !sda) begin
            // Advance early so read data settles before the next falling edge
            ptr_ff <= ptr_ff + 8'h01;
        end
    end

    // ****************************************
    // SDA drive, open drain
    // ****************************************
    // SDA is only ever pulled low, never driven high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_oe_ff <= 1'b0;
            tx_ff <= 8'h00;
        end else if (bus_start || bus_stop || arb_lost) begin
            sda_oe_ff <= 1'b0;
        end else if (scl_fall) begin
            case (state_ff)
                gsl_pkg::S_ADDR: begin
                    sda_oe_ff <= (cnt_ff == gsl_pkg::BITS_PER_BYTE) & (own_hit | ara_hit);
                end
                gsl_pkg::S_CMD, gsl_pkg::S_WDATA: begin
                    sda_oe_ff <= cnt_ff == gsl_pkg::BITS_PER_BYTE;
                end
                gsl_pkg::S_ACK: begin
                    if (after_ff == gsl_pkg::S_RDATA) begin
                        tx_ff <= reg_rdata;
                        sda_oe_ff <= ~reg_rdata[7];
                    end else if (after_ff == gsl_pkg::S_ARA) begin
                        // own address followed by a one
                        tx_ff <= {gsl_pkg::DEV_ADDR, 1'b1};
                        sda_oe_ff <= ~gsl_pkg::DEV_ADDR[6];
                    end else begin
                        sda_oe_ff <= 1'b0;
                    end
                end
                gsl_pkg::S_RDATA, gsl_pkg::S_ARA: begin
                    if (cnt_ff == gsl_pkg::BITS_PER_BYTE) begin
                        sda_oe_ff <= 1'b0;
                    end else begin
                        tx_ff <= {tx_ff[6:0], 1'b0};
                        sda_oe_ff <= ~tx_ff[6];
                    end
                end
                gsl_pkg::S_RACK: begin
                    tx_ff <= reg_rdata;
                    sda_oe_ff <= ~rx_ff[0] & ~reg_rdata[7];
                end
                default: begin
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Register file strobes
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_req_ff <= '0;
        end else begin
            reg_req_ff.addr <= ptr_ff;
            reg_req_ff.wr <= state_ff == gsl_pkg::S_WDATA && byte_end;
            reg_req_ff.wdata <= (state_ff == gsl_pkg::S_WDATA && byte_end) ? rx_ff :
                reg_req_ff.wdata;
            reg_req_ff.rd <= scl_fall && ((state_ff == gsl_pkg::S_ACK &&
                after_ff == gsl_pkg::S_RDATA) || (state_ff == gsl_pkg::S_RACK && !rx_ff[0]));
        end
    end

    // ****************************************
    // Alert pin and bus status
    // ****************************************
    // set wins over clear so a fresh event is never lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_pend_ff <= 1'b0;
        end else if (alert_event) begin
            alert_pend_ff <= 1'b1;
        end else if (ara_done) begin
            alert_pend_ff <= 1'b0;
        end
    end

    // pull low only in alert mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_oe_ff <= 1'b0;
        end else begin
            // upper config bit selects alert mode
            alert_oe_ff <= alert_pend_ff & alert_cfg[gsl_pkg::ALERT_MODE_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
        end else if (bus_start) begin
            busy_ff <= 1'b1;
        end else if (bus_stop) begin
            busy_ff <= 1'b0;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign alert_charge_complete_pin_o = 1'b0;
    assign alert_charge_complete_pin_oe = alert_oe_ff;
    assign reg_req = reg_req_ff;
    assign bus_busy = busy_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_byte_end(gsl_pkg::gsl_state_t st);
        scl_fall && state_ff == st && cnt_ff == gsl_pkg::BITS_PER_BYTE;
    endsequence

    sequence s_own_write;
        s_byte_end(gsl_pkg::S_ADDR) ##0 own_hit && !rx_ff[0];
    endsequence

    a_restart_to_addr: assert property (bus_start |=> state_ff == gsl_pkg::S_ADDR)
        else $error("start did not restart address phase");
    a_stop_frees_bus: assert property (bus_stop && !bus_start |=>
        state_ff == gsl_pkg::S_IDLE && !sda_oe_ff && !busy_ff)
        else $error("stop did not free the bus");
    a_pull_scl_low: assert property ($rose(sda_oe_ff) |-> !scl_q_ff)
        else $error("SDA pulled low while SCL high");
    a_own_addr_ack: assert property (s_own_write |=> sda_oe_ff && after_ff == gsl_pkg::S_CMD
        ##1 (sda_oe_ff && state_ff == gsl_pkg::S_ACK) [*2])
        else $error("own write address not acknowledged");
    a_cmd_loads_ptr: assert property (s_byte_end(gsl_pkg::S_CMD) |=>
        ptr_ff == $past(rx_ff) && sda_oe_ff)
        else $error("command byte did not load pointer");
    a_write_strobe: assert property (s_byte_end(gsl_pkg::S_WDATA) |=>
        reg_req_ff.wr && reg_req_ff.wdata == $past(rx_ff)
        && reg_req_ff.addr == $past(ptr_ff) ##1 !reg_req_ff.wr)
        else $error("write byte not stored once at pointer");
    a_foreign_nack: assert property (s_byte_end(gsl_pkg::S_ADDR) ##0 !own_hit && !ara_hit
        |=> !sda_oe_ff && state_ff == gsl_pkg::S_SKIP)
        else $error("foreign address acknowledged");
    a_arb_abort: assert property (arb_lost |=> !sda_oe_ff && state_ff == gsl_pkg::S_SKIP
        && alert_pend_ff == ($past(alert_pend_ff) | $past(alert_event)))
        else $error("lost arbitration not aborted");
    a_ara_release: assert property (ara_done && !alert_event |=> ##1 !alert_oe_ff)
        else $error("alert pin held after alert response");
    a_alert_mode: assert property (alert_oe_ff |->
        $past(alert_cfg[gsl_pkg::ALERT_MODE_BIT]) && $past(alert_pend_ff))
        else $error("alert pin asserted outside alert mode");
    a_ara_gate: assert property (s_byte_end(gsl_pkg::S_ADDR) ##0 !own_hit && !alert_oe_ff
        |=> !sda_oe_ff)
        else $error("alert address acknowledged without alert");

endmodule // gsl_slave

// ### gsl_slave_tb.sv
// Purpose: Self-checking bench of the gauge two-wire slave
// Assumes: Register file modelled here, read combinationally
// Notes: Random data from a fixed seed, corner cases by hand
`timescale 1ns/100ps

module gsl_slave_tb;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [7:0] WR_A = {gsl_pkg::DEV_ADDR, 1'b0};
    localparam logic [7:0] RD_A = {gsl_pkg::DEV_ADDR, 1'b1};
    logic clk;
    logic rst;
    logic scl;
    logic sda;
    logic m_pull;
    logic r_pull;
    logic sda_o;
    logic sda_oe;
    logic pin_o;
    logic pin_oe;
    logic alert_event;
    logic [1:0] alert_cfg;
    gsl_pkg::gsl_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic bus_busy;
    logic [7:0] regs [256];
    logic [7:0] exp_regs [256];
    int bad_count;
    int tests_run;
    int rd_seen;

    assign sda = ~(m_pull | r_pull | (sda_oe & ~sda_o));
    assign reg_rdata = regs[reg_req.addr];
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (reg_req.wr) begin
            regs[reg_req.addr] <= reg_req.wdata;
        end
    end
    // Counts read strobes so each read byte is seen to be taken once
    always @(posedge clk) begin
        if (reg_req.rd) begin
            rd_seen <= rd_seen + 1;
        end
    end

    gsl_slave i_gsl_slave (
        .clk(clk), .rst(rst), .scl(scl), .sda(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .alert_charge_complete_pin_o(pin_o), .alert_charge_complete_pin_oe(pin_oe),
        .alert_event(alert_event), .alert_cfg(alert_cfg), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .bus_busy(bus_busy));
    gsl_bus_master i_gsl_bus_master (
        .clk(clk), .sda(sda), .scl(scl), .sda_pull(m_pull), .rival_pull(r_pull));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] ara_reply();
        return RD_A;
    endfunction

    // Lower value wins arbitration, so the wire then shows the winner
    function automatic logic [7:0] arb_view(input logic [7:0] own, input logic [7:0] other);
        return (other < own) ? other : own;
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic wb(input logic [7:0] b, input logic exp_ack, input string what);
        logic ack;
        i_gsl_bus_master.write_byte(b, ack);
        check(what, 8'(ack), 8'(exp_ack));
    endtask

    task automatic ara(input logic exp_ack, input logic [7:0] rival, input string what);
        logic [7:0] got;
        i_gsl_bus_master.start_cond();
        wb({gsl_pkg::ARA_ADDR, 1'b1}, exp_ack, what);
        if (exp_ack) begin
            i_gsl_bus_master.read_byte(1'b0, rival, got);
            check(what, got, arb_view(ara_reply(), rival));
        end
        i_gsl_bus_master.stop_cond();
    endtask

    task automatic pulse_event();
        alert_event = 1'b1;
        @(posedge clk);
        #1;
        alert_event = 1'b0;
    endtask

    // Bounded wait; running out ends the run
    task automatic wait_pin(input logic want);
        int k;
        k = 0;
        while (pin_oe !== want && k < 16) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("alert pin", 8'(pin_oe), 8'(want));
        check("alert pin level", 8'(pin_o), 8'h00);
        if (pin_oe !== want) summarize();
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] cmd;
        logic [7:0] c1;
        logic [7:0] got;
        logic [6:0] bad_a;
        int rd_base;
        clk = 1'b0;
        rst = 1'b1;
        alert_event = 1'b0;
        alert_cfg = 2'b00;
        bad_count = 0;
        tests_run = 0;
        void'($urandom(32'h0356));
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'h00;
            exp_regs[i] = 8'h00;
        end
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        check("busy after reset", 8'(bus_busy), 8'h00);
        check("sda after reset", 8'(sda_oe), 8'h00);
        // Pointer wrap at the top register first, then random places
        for (int n = 0; n < 4; n++) begin
            cmd = (n == 0) ? 8'hff : 8'($urandom);
            c1 = cmd + 8'h01;
            exp_regs[cmd] = 8'($urandom);
            exp_regs[c1] = 8'($urandom);
            i_gsl_bus_master.start_cond();
            wb(WR_A, 1'b1, "write address");
            wb(cmd, 1'b1, "command");
            wb(exp_regs[cmd], 1'b1, "first data");
            wb(exp_regs[c1], 1'b1, "next data");
            i_gsl_bus_master.stop_cond();
            check("busy after stop", 8'(bus_busy), 8'h00);
            check("stored first", regs[cmd], exp_regs[cmd]);
            check("stored next", regs[c1], exp_regs[c1]);
            i_gsl_bus_master.start_cond();
            wb(WR_A, 1'b1, "pointer address");
            wb(cmd, 1'b1, "read command");
            i_gsl_bus_master.start_cond();
            check("busy at restart", 8'(bus_busy), 8'h01);
            rd_base = rd_seen;
            wb(RD_A, 1'b1, "read address");
            i_gsl_bus_master.read_byte(1'b1, 8'hff, got);
            check("read first", got, exp_regs[cmd]);
            i_gsl_bus_master.read_byte(1'b0, 8'hff, got);
            check("read next", got, exp_regs[c1]);
            check("read strobes", 8'(rd_seen - rd_base), 8'h02);
            i_gsl_bus_master.stop_cond();
            $display("Test transfer %0d done", n);
        end
        bad_a = 7'($urandom);
        if (bad_a == gsl_pkg::DEV_ADDR || bad_a == gsl_pkg::ARA_ADDR) bad_a = bad_a ^ 7'h01;
        i_gsl_bus_master.start_cond();
        wb({bad_a, 1'($urandom)}, 1'b0, "foreign address");
        i_gsl_bus_master.stop_cond();
        $display("Test foreign address done");
        alert_cfg = 2'b01;
        pulse_event();
        repeat (4) @(posedge clk);
        #1;
        check("pin with mode off", 8'(pin_oe), 8'h00);
        ara(1'b0, 8'hff, "alert unpulled");
        alert_cfg = 2'b10;
        wait_pin(1'b1);
        i_gsl_bus_master.start_cond();
        wb({gsl_pkg::ARA_ADDR, 1'b0}, 1'b0, "alert write bit");
        i_gsl_bus_master.stop_cond();
        ara(1'b1, 8'h21, "alert lost");
        check("pin after loss", 8'(pin_oe), 8'h01);
        ara(1'b1, 8'hff, "alert reply");
        wait_pin(1'b0);
        ara(1'b0, 8'hff, "alert after release");
        pulse_event();
        wait_pin(1'b1);
        ara(1'b1, 8'hff, "alert new event");
        $display("Test alert response done");
        summarize();
    end
endmodule // gsl_slave_tb
